/* File: core/utrd_map.vh */
// register map, field positions, reset values and counts of the serial data path
// Behaviour
// - while transmit enabled, the block owns and drives the serial output pin
// - synchronous mode: transmit bits are timed by the external sync clock pin
// - writing the data location loads the transmit buffer and starts sending
// - buffer moves to shifter when idle or right after the last stop bit
// - shifter sends one whole frame at baud divisor rate or external clock
// - below eight bits, unused upper bits of written data are ignored
// - nine-bit characters send the ninth bit latched from the ninth-bit field
// - buffer empty flag is one exactly while the transmit buffer is empty
// - buffer empty request stays asserted while enabled and flag set
// - transmit complete sets when frame left and no data buffered
// - transmit complete clears when its interrupt is taken or one is written
// - transmit complete request follows the flag when enabled
// - parity enabled: parity bit goes after last data bit, before stop
// - disabling the transmitter waits until buffer and shifter are empty
// - while receive enabled, the block owns the serial input pin
// - synchronous mode: receive bits are sampled on the external clock
// - reception starts on a valid start bit, bits shift in until stop
// - a second stop bit is ignored; frame ends at the first stop bit
// - after the first stop bit the frame moves into the receive buffer
// - below eight bits, unused upper bits read from data are zero
// - frame is low start, data LSB first, optional parity, high stops
// - parity is xor of data bits, inverted for odd parity
// - normal asynchronous bit rate is clock over sixteen times divisor plus one
// - receive complete flag is one while unread data sits in the buffer
`ifndef UTRD_MAP_VH
`define UTRD_MAP_VH
`define UTRD_OFS_DATA   8'h00
`define UTRD_OFS_A      8'h04
`define UTRD_OFS_B      8'h08
`define UTRD_OFS_C      8'h0C
`define UTRD_OFS_BAUD   8'h10
`define UTRD_A_RXC      7
`define UTRD_A_TXC      6
`define UTRD_A_UDRE     5
`define UTRD_A_U2X      1
`define UTRD_B_TXCIE    6
`define UTRD_B_UDRIE    5
`define UTRD_B_RXEN     4
`define UTRD_B_TX_ON    3
`define UTRD_B_CSZ2     2
`define UTRD_B_RX9      1
`define UTRD_B_TX9      0
`define UTRD_C_SYNC     6
`define UTRD_C_PEN      5
`define UTRD_C_PODD     4
`define UTRD_C_STOP2    3
`define UTRD_C_CSZ1     2
`define UTRD_C_CSZ0     1
`define UTRD_C_CPOL     0
`define UTRD_RST_CSZ    3'h3
`define UTRD_RST_BAUD   12'h000
`define UTRD_OS_NORM    4'hF
`define UTRD_OS_DBL     4'h7
`define UTRD_MID_NORM   4'h8
`define UTRD_MID_DBL    4'h4
`define UTRD_CSZ_NINE   3'h7
`define UTRD_NB_BASE    4'h5
`define UTRD_NB_NINE    4'h9
`endif

/* File: core/utrd_sync.v */
// two-stage synchronisers for the pin inputs, one per bit
module utrd_sync (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [1:0] din,
	output wire [1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			// idle lines are high, so reset to one avoids a false start
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta   <= 1'b1;
					stable <= 1'b1;
				end else begin
					meta   <= din[i];
					stable <= meta;
				end
			end
			assign dout[i] = stable;
		end
	endgenerate
endmodule // utrd_sync

/* File: core/utrd_baud.v */
// sample tick generator: one tick every divisor plus one clocks
module utrd_baud (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [11:0] divisor,
	output reg         tick
);
	reg [11:0] cnt;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= 12'h000;
			tick <= 1'b0;
		end else if (cnt == 12'h000) begin
			cnt  <= divisor;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt - 12'h001;
			tick <= 1'b0;
		end
	end
endmodule // utrd_baud

/* File: core/utrd_top.v */
// serial transceiver transmit and receive data path with apb registers
//
// The implementer's own choices: the register offsets and the APB register port.
`include "utrd_map.vh"
module utrd_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        global_irq_enable,
	input  wire        txc_irq_taken,
	input  wire        serial_in_pin,
	input  wire        ext_sync_clock_pin,
	output reg         serial_out_pin,
	output reg         serial_out_oe,
	output reg         serial_in_own,
	output reg         udre_irq,
	output reg         txc_irq
);
	localparam T_IDLE  = 3'h0;
	localparam T_START = 3'h1;
	localparam T_DATA  = 3'h2;
	localparam T_PAR   = 3'h3;
	localparam T_STOP  = 3'h4;
	localparam R_IDLE  = 3'h0;
	localparam R_START = 3'h1;
	localparam R_DATA  = 3'h2;
	localparam R_PAR   = 3'h3;
	localparam R_STOP  = 3'h4;

	// control fields
	reg        double_speed_bit;
	reg        transmit_complete_irq_enable;
	reg        buffer_empty_irq_enable;
	reg        receive_enable_bit;
	reg        transmit_enable_bit;
	reg        tx_ninth_bit;
	reg [2:0]  char_size_field;
	reg        sync_mode;
	reg        parity_enable_bit;
	reg        parity_odd_select;
	reg        stop_count_select;
	reg        clock_polarity;
	reg [11:0] baud_divisor;

	// transmit state
	reg [7:0]  tx_buf;
	reg        tx_buf9;
	reg        tx_full;
	reg        transmit_complete_flag;
	reg        tx_on;
	reg [2:0]  tx_state;
	reg [8:0]  tx_shift;
	reg [3:0]  tx_bit;
	reg [3:0]  tx_cnt;
	reg        tx_second;
	reg        tx_par;

	// receive state
	reg [2:0]  rx_state;
	reg [3:0]  rx_cnt;
	reg [2:0]  rx_votes;
	reg [3:0]  rx_bit;
	reg [8:0]  rx_shift;
	reg [8:0]  rx_buf;
	reg        receive_complete_flag;

	reg        xck_prev;
	reg [31:0] rd_mux;
	reg        mapped;

	wire [1:0] synced;
	wire       tick;
	wire       rxd  = synced[0];
	wire       xck  = synced[1];

	utrd_sync u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.din   ({ext_sync_clock_pin, serial_in_pin}),
		.dout  (synced)
	);

	utrd_baud u_baud (
		.clk     (pclk),
		.rst_n   (presetn),
		.divisor (baud_divisor),
		.tick    (tick)
	);

	// frame geometry
	wire       nine     = (char_size_field == `UTRD_CSZ_NINE);
	wire [3:0] nbits    = nine ? `UTRD_NB_NINE : ({1'b0, char_size_field} + `UTRD_NB_BASE);
	wire [3:0] os_last  = double_speed_bit ? `UTRD_OS_DBL : `UTRD_OS_NORM;
	wire [3:0] os_mid   = double_speed_bit ? `UTRD_MID_DBL : `UTRD_MID_NORM;
	wire [3:0] nb_gap   = `UTRD_NB_NINE - nbits;
	wire [8:0] dmask    = 9'h1FF >> nb_gap;
	wire [8:0] tx_data  = {tx_buf9, tx_buf} & dmask;
	wire       tx_pcalc = (^tx_data) ^ parity_odd_select;
	wire [8:0] rx_align = rx_shift >> nb_gap;
	wire [8:0] rx_read  = rx_buf & dmask;

	// external clock edges after the synchroniser
	wire xck_rise  = xck & ~xck_prev;
	wire xck_fall  = ~xck & xck_prev;
	wire chg_edge  = clock_polarity ? xck_fall : xck_rise;
	wire smp_edge  = clock_polarity ? xck_rise : xck_fall;

	// apb handshake: one wait state so read data comes from a flop
	wire setup_acc = psel & penable & ~pready;
	wire acc       = psel & penable & pready;
	wire wr        = acc & pwrite;
	wire rd        = acc & ~pwrite;
	wire hit_data  = (paddr == `UTRD_OFS_DATA);
	wire hit_a     = (paddr == `UTRD_OFS_A);
	wire hit_b     = (paddr == `UTRD_OFS_B);
	wire hit_c     = (paddr == `UTRD_OFS_C);
	wire hit_baud  = (paddr == `UTRD_OFS_BAUD);
	wire wr_data   = wr & hit_data;

	// transmit sequencing
	wire tx_step   = sync_mode ? chg_edge : (tick & (tx_cnt == os_last));
	wire tx_end    = tx_step & (tx_state == T_STOP) & (~stop_count_select | tx_second);
	wire tx_load   = tx_full & tx_on & ((tx_state == T_IDLE) | tx_end);

	// receive sequencing
	wire majority  = (rx_votes[0] & rx_votes[1]) | (rx_votes[0] & rx_votes[2])
	               | (rx_votes[1] & rx_votes[2]);
	wire rx_done   = sync_mode ? smp_edge : (tick & (rx_cnt == os_last));
	wire rx_val    = sync_mode ? rxd : majority;
	wire rx_store  = rx_done & (rx_state == R_STOP) & receive_enable_bit;
	wire in_window = (rx_cnt >= os_mid - 4'h1) && (rx_cnt <= os_mid + 4'h1);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			xck_prev <= 1'b1;
		else
			xck_prev <= xck;
	end

	// register read mux
	always @* begin
		rd_mux = 32'h00000000;
		mapped = 1'b1;
		if (hit_data) begin
			rd_mux[7:0] = rx_read[7:0];
		end else if (hit_a) begin
			rd_mux[`UTRD_A_RXC]  = receive_complete_flag;
			rd_mux[`UTRD_A_TXC]  = transmit_complete_flag;
			rd_mux[`UTRD_A_UDRE] = ~tx_full;
			rd_mux[`UTRD_A_U2X]  = double_speed_bit;
		end else if (hit_b) begin
			rd_mux[`UTRD_B_TXCIE] = transmit_complete_irq_enable;
			rd_mux[`UTRD_B_UDRIE] = buffer_empty_irq_enable;
			rd_mux[`UTRD_B_RXEN]  = receive_enable_bit;
			rd_mux[`UTRD_B_TX_ON] = transmit_enable_bit;
			rd_mux[`UTRD_B_CSZ2]  = char_size_field[2];
			rd_mux[`UTRD_B_RX9]   = rx_read[8];
			rd_mux[`UTRD_B_TX9]   = tx_ninth_bit;
		end else if (hit_c) begin
			rd_mux[`UTRD_C_SYNC]  = sync_mode;
			rd_mux[`UTRD_C_PEN]   = parity_enable_bit;
			rd_mux[`UTRD_C_PODD]  = parity_odd_select;
			rd_mux[`UTRD_C_STOP2] = stop_count_select;
			rd_mux[`UTRD_C_CSZ1]  = char_size_field[1];
			rd_mux[`UTRD_C_CSZ0]  = char_size_field[0];
			rd_mux[`UTRD_C_CPOL]  = clock_polarity;
		end else if (hit_baud) begin
			rd_mux[11:0] = baud_divisor;
		end else begin
			mapped = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup_acc;
			pslverr <= setup_acc & ~mapped;
			if (setup_acc)
				prdata <= rd_mux;
		end
	end

	// control register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			double_speed_bit             <= 1'b0;
			transmit_complete_irq_enable <= 1'b0;
			buffer_empty_irq_enable      <= 1'b0;
			receive_enable_bit           <= 1'b0;
			transmit_enable_bit          <= 1'b0;
			tx_ninth_bit                 <= 1'b0;
			char_size_field              <= `UTRD_RST_CSZ;
			sync_mode                    <= 1'b0;
			parity_enable_bit            <= 1'b0;
			parity_odd_select            <= 1'b0;
			stop_count_select            <= 1'b0;
			clock_polarity               <= 1'b0;
			baud_divisor                 <= `UTRD_RST_BAUD;
		end else if (wr) begin
			if (hit_a) begin
				// empty flag position is not writable
				double_speed_bit <= pwdata[`UTRD_A_U2X];
			end else if (hit_b) begin
				transmit_complete_irq_enable <= pwdata[`UTRD_B_TXCIE];
				buffer_empty_irq_enable      <= pwdata[`UTRD_B_UDRIE];
				receive_enable_bit           <= pwdata[`UTRD_B_RXEN];
				transmit_enable_bit          <= pwdata[`UTRD_B_TX_ON];
				char_size_field[2]           <= pwdata[`UTRD_B_CSZ2];
				tx_ninth_bit                 <= pwdata[`UTRD_B_TX9];
			end else if (hit_c) begin
				sync_mode          <= pwdata[`UTRD_C_SYNC];
				parity_enable_bit  <= pwdata[`UTRD_C_PEN];
				parity_odd_select  <= pwdata[`UTRD_C_PODD];
				stop_count_select  <= pwdata[`UTRD_C_STOP2];
				char_size_field[1] <= pwdata[`UTRD_C_CSZ1];
				char_size_field[0] <= pwdata[`UTRD_C_CSZ0];
				clock_polarity     <= pwdata[`UTRD_C_CPOL];
			end else if (hit_baud) begin
				baud_divisor <= pwdata[11:0];
			end
		end
	end

	// transmit buffer, complete flag and deferred disable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buf                 <= 8'h00;
			tx_buf9                <= 1'b0;
			tx_full                <= 1'b0;
			transmit_complete_flag <= 1'b0;
			tx_on                  <= 1'b0;
		end else begin
			if (wr_data) begin
				tx_buf  <= pwdata[7:0];
				tx_buf9 <= tx_ninth_bit;
				tx_full <= 1'b1;
			end else if (tx_load) begin
				tx_full <= 1'b0;
			end
			// a completion in the same cycle as a clear wins
			if (tx_end & ~tx_full)
				transmit_complete_flag <= 1'b1;
			else if (txc_irq_taken | (wr & hit_a & pwdata[`UTRD_A_TXC]))
				transmit_complete_flag <= 1'b0;
			if (transmit_enable_bit)
				tx_on <= 1'b1;
			else if ((tx_state == T_IDLE) & ~tx_full)
				tx_on <= 1'b0;
		end
	end

	// transmit shifter
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state       <= T_IDLE;
			tx_shift       <= 9'h000;
			tx_bit         <= 4'h0;
			tx_cnt         <= 4'h0;
			tx_second      <= 1'b0;
			tx_par         <= 1'b0;
			serial_out_pin <= 1'b1;
		end else begin
			if ((tx_state != T_IDLE) & tick)
				tx_cnt <= (tx_cnt == os_last) ? 4'h0 : tx_cnt + 4'h1;
			if (tx_load) begin
				tx_state       <= T_START;
				tx_shift       <= tx_data;
				tx_par         <= tx_pcalc;
				tx_cnt         <= 4'h0;
				tx_second      <= 1'b0;
				serial_out_pin <= 1'b0;
			end else if (tx_state == T_IDLE) begin
				serial_out_pin <= 1'b1;
			end else if (tx_step) begin
				case (tx_state)
					T_START: begin
						serial_out_pin <= tx_shift[0];
						tx_shift       <= tx_shift >> 1;
						tx_bit         <= 4'h0;
						tx_state       <= T_DATA;
					end
					T_DATA: begin
						if (tx_bit == nbits - 4'h1) begin
							if (parity_enable_bit) begin
								serial_out_pin <= tx_par;
								tx_state       <= T_PAR;
							end else begin
								serial_out_pin <= 1'b1;
								tx_state       <= T_STOP;
							end
						end else begin
							serial_out_pin <= tx_shift[0];
							tx_shift       <= tx_shift >> 1;
							tx_bit         <= tx_bit + 4'h1;
						end
					end
					T_PAR: begin
						serial_out_pin <= 1'b1;
						tx_state       <= T_STOP;
					end
					T_STOP: begin
						if (stop_count_select & ~tx_second)
							tx_second <= 1'b1;
						else
							tx_state <= T_IDLE;
					end
					default: tx_state <= T_IDLE;
				endcase
			end
		end
	end

	// receiver; disabling is immediate and flushes the buffer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= R_IDLE;
			rx_cnt   <= 4'h0;
			rx_votes <= 3'h7;
			rx_bit   <= 4'h0;
			rx_shift <= 9'h000;
		end else if (!receive_enable_bit) begin
			rx_state <= R_IDLE;
		end else begin
			if ((rx_state != R_IDLE) & tick & ~sync_mode) begin
				rx_cnt <= (rx_cnt == os_last) ? 4'h0 : rx_cnt + 4'h1;
				if (in_window)
					rx_votes <= {rx_votes[1:0], rxd};
			end
			case (rx_state)
				R_IDLE: begin
					rx_bit <= 4'h0;
					if (sync_mode) begin
						if (smp_edge & ~rxd)
							rx_state <= R_DATA;
					end else if (tick & ~rxd) begin
						rx_cnt   <= 4'h1;
						rx_votes <= 3'h7;
						rx_state <= R_START;
					end
				end
				R_START: begin
					// a low glitch that loses the vote is not a start
					if (rx_done)
						rx_state <= majority ? R_IDLE : R_DATA;
				end
				R_DATA: begin
					if (rx_done) begin
						rx_shift <= {rx_val, rx_shift[8:1]};
						if (rx_bit == nbits - 4'h1)
							rx_state <= parity_enable_bit ? R_PAR : R_STOP;
						else
							rx_bit <= rx_bit + 4'h1;
					end
				end
				R_PAR: begin
					if (rx_done)
						rx_state <= R_STOP;
				end
				R_STOP: begin
					if (rx_done)
						rx_state <= R_IDLE;
				end
				default: rx_state <= R_IDLE;
			endcase
		end
	end

	// receive buffer and complete flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf                <= 9'h000;
			receive_complete_flag <= 1'b0;
		end else if (!receive_enable_bit) begin
			receive_complete_flag <= 1'b0;
		end else if (rx_store) begin
			rx_buf                <= rx_align;
			receive_complete_flag <= 1'b1;
		end else if (rd & hit_data) begin
			receive_complete_flag <= 1'b0;
		end
	end

	// pin ownership and interrupt requests
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_oe <= 1'b0;
			serial_in_own <= 1'b0;
			udre_irq      <= 1'b0;
			txc_irq       <= 1'b0;
		end else begin
			serial_out_oe <= tx_on;
			serial_in_own <= receive_enable_bit;
			udre_irq      <= buffer_empty_irq_enable & global_irq_enable & ~tx_full;
			txc_irq       <= transmit_complete_irq_enable & global_irq_enable
			                 & transmit_complete_flag;
		end
	end
endmodule // utrd_top

/* File: bench/utrd_props.sv */
// concurrent checks on the serial data path top-level ports
module utrd_props (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic pslverr,
	input logic global_irq_enable,
	input logic txc_irq_taken,
	input logic serial_out_pin,
	input logic serial_out_oe,
	input logic udre_irq,
	input logic txc_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && $rose(penable);
	endsequence
	// start bit may lose up to one tick of its first period
	sequence s_start_low;
		!serial_out_pin [*6];
	endsequence
	AST_APB_ANSWER: assert property (s_access |=> pready)
		else $error("access not answered after one wait state");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_SLVERR_READY: assert property (pslverr |-> pready)
		else $error("error response without ready");
	AST_LINE_OWNED: assert property (!serial_out_pin |-> serial_out_oe)
		else $error("output line low while not owned");
	AST_START_LEN: assert property ($fell(serial_out_pin) |-> s_start_low)
		else $error("start bit too short");
	AST_OE_RELEASE: assert property ($fell(serial_out_oe) |-> serial_out_pin)
		else $error("output pin released in mid frame");
	AST_UDRE_GATE: assert property (udre_irq |-> $past(global_irq_enable))
		else $error("buffer empty request without global enable");
	AST_TXC_GATE: assert property (txc_irq |-> $past(global_irq_enable))
		else $error("transmit complete request without global enable");
	AST_TXC_IDLE: assert property ($rose(txc_irq) |-> serial_out_pin)
		else $error("transmit complete raised while frame on line");
	AST_TXC_TAKEN: assert property (txc_irq && txc_irq_taken |-> ##[1:3] !txc_irq)
		else $error("transmit complete not cleared when taken");
endmodule // utrd_props

bind utrd_top utrd_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr),
	.global_irq_enable(global_irq_enable), .txc_irq_taken(txc_irq_taken),
	.serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
	.udre_irq(udre_irq), .txc_irq(txc_irq));

/* File: bench/utrd_partner.sv */
// behavioural remote serial transceiver on the transmit and receive lines
module utrd_partner (
	input  logic clk,
	input  logic line_in,
	output logic line_out,
	input  int   bitc,
	input  int   flen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] frames[$];
	logic [31:0] f;
	initial line_out = 1'b1;
	// centre sampling, no extra wait after the last bit so a following start is seen
	always begin
		@(negedge line_in);
		f = 32'h0;
		repeat (bitc / 2) @(posedge clk);
		for (int i = 0; i < flen; i++) begin
			f[i] = line_in;
			if (i < flen - 1)
				repeat (bitc) @(posedge clk);
		end
		frames.push_back(f);
	end
	task send(input logic [31:0] b, input int len);
		for (int i = 0; i < len; i++) begin
			@(posedge clk);
			line_out <= b[i];
			repeat (bitc - 1) @(posedge clk);
		end
	endtask
	task glitch();
		@(posedge clk);
		line_out <= 1'b0;
		repeat (3) @(posedge clk);
		line_out <= 1'b1;
	endtask
endmodule // utrd_partner

/* File: bench/usart_tx_rx_datapath_tb.sv */
// self-checking bench for the serial transmit and receive data path
`include "utrd_map.vh"
module usart_tx_rx_datapath_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, gie, taken, err, xck;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, sin, sout, soe, sown, udre_irq, txc_irq;
	logic [2:0]  csz;
	logic [8:0]  d, d2;
	int          checks, mismatches, bitc, flen, n, pen, odd, u2x, dv;
	int          tn[5] = '{8, 5, 7, 9, 6};
	int          tp[5] = '{0, 1, 1, 1, 0};
	int          to[5] = '{0, 0, 1, 0, 0};
	int          tu[5] = '{0, 0, 1, 0, 0};
	int          tdv[5] = '{0, 0, 1, 1, 0};
	logic [8:0]  td[5] = '{9'h055, 9'h1F7, 9'h04B, 9'h1A6, 9'h02D};

	utrd_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .global_irq_enable(gie),
		.txc_irq_taken(taken), .serial_in_pin(sin), .ext_sync_clock_pin(xck),
		.serial_out_pin(sout), .serial_out_oe(soe), .serial_in_own(sown),
		.udre_irq(udre_irq), .txc_irq(txc_irq));
	utrd_partner peer (.clk(pclk), .line_in(sout), .line_out(sin), .bitc(bitc), .flen(flen));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// whole run needs well under a tenth of this
	initial begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		report_and_stop();
	end

	task report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] wd);
		xfer(1'b1, a, wd);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		check(r & m, e);
	endtask
	task settle(input int k);
		repeat (k) @(posedge pclk);
		@(negedge pclk);
	endtask
	task wait_tx(input int k);
		int t;
		t = 0;
		while (peer.frames.size() < k && t < 5000) begin
			@(posedge pclk);
			t++;
		end
		check(32'(peer.frames.size()), 32'(k));
		repeat (bitc) @(posedge pclk);
	endtask
	function automatic logic [31:0] mk(input logic [8:0] v, input int nb, p, o, len);
		logic [31:0] b;
		b = (32'h1 << len) - 32'h1;
		b[0] = 1'b0;
		for (int i = 0; i < nb; i++)
			b[i + 1] = v[i];
		if (p != 0)
			b[nb + 1] = ^(v & ((9'h1 << nb) - 9'h1)) ^ o[0];
		return b;
	endfunction

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, gie, taken, xck} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		{checks, mismatches, bitc, flen} = {32'd0, 32'd0, 32'd16, 32'd10};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(`UTRD_OFS_A, 32'hFFFFFFFF, 32'h20);
		rd(`UTRD_OFS_C, 32'hFFFFFFFF, 32'h06);
		rd(8'h14, 32'hFFFFFFFF, 32'h0);
		check({31'h0, err}, 32'h1);
		wr(`UTRD_OFS_B, 32'h08);
		// enable flop, ownership flop, then the registered output
		settle(2);
		check({31'h0, soe}, 32'h1);
		for (int k = 0; k < 5; k++) begin
			{n, pen, odd, u2x, dv, d} = {tn[k], tp[k], to[k], tu[k], tdv[k], td[k]};
			csz = (n == 9) ? `UTRD_CSZ_NINE : 3'(n - 5);
			bitc = (u2x != 0 ? 8 : 16) * (dv + 1);
			flen = n + pen + 2;
			d2 = ~d;
			wr(`UTRD_OFS_A, {25'h0, 1'b1, 4'h0, u2x[0], 1'b0});
			wr(`UTRD_OFS_BAUD, 32'(dv));
			wr(`UTRD_OFS_C, {26'h0, pen[0], odd[0], 1'b0, csz[1:0], 1'b0});
			wr(`UTRD_OFS_B, {28'h0, 1'b1, csz[2], 1'b0, d[8]});
			wr(`UTRD_OFS_DATA, {24'h0, d[7:0]});
			wr(`UTRD_OFS_B, {28'h0, 1'b1, csz[2], 1'b0, d2[8]});
			wr(`UTRD_OFS_DATA, {24'h0, d2[7:0]});
			rd(`UTRD_OFS_A, 32'h20, 32'h0);
			wait_tx(2);
			check(peer.frames.pop_front(), mk(d, n, pen, odd, flen));
			check(peer.frames.pop_front(), mk(d2, n, pen, odd, flen));
			rd(`UTRD_OFS_A, 32'h60, 32'h60);
		end
		wr(`UTRD_OFS_B, 32'h48);
		@(posedge pclk);
		gie <= 1'b1;
		settle(3);
		check({31'h0, txc_irq}, 32'h1);
		@(posedge pclk);
		taken <= 1'b1;
		@(posedge pclk);
		taken <= 1'b0;
		settle(3);
		check({31'h0, txc_irq}, 32'h0);
		rd(`UTRD_OFS_A, 32'h40, 32'h0);
		wr(`UTRD_OFS_B, 32'h28);
		settle(2);
		check({31'h0, udre_irq}, 32'h1);
		wr(`UTRD_OFS_B, 32'h08);
		settle(2);
		check({31'h0, udre_irq}, 32'h0);
		@(posedge pclk);
		gie <= 1'b0;
		wr(`UTRD_OFS_DATA, 32'h33);
		wr(`UTRD_OFS_B, 32'h00);
		settle(1);
		check({31'h0, soe}, 32'h1);
		wait_tx(1);
		check(peer.frames.pop_front(), mk(9'h033, 6, 0, 0, 8));
		settle(2);
		check({31'h0, soe}, 32'h0);
		wr(`UTRD_OFS_C, 32'h0E);
		wr(`UTRD_OFS_B, 32'h10);
		settle(1);
		check({31'h0, sown}, 32'h1);
		peer.glitch();
		settle(60);
		rd(`UTRD_OFS_A, 32'h80, 32'h0);
		peer.send(mk(9'h0A5, 8, 0, 0, 10), 10);
		peer.send(mk(9'h03C, 8, 0, 0, 10), 10);
		settle(4);
		rd(`UTRD_OFS_A, 32'h80, 32'h80);
		rd(`UTRD_OFS_DATA, 32'hFFFFFFFF, 32'h3C);
		rd(`UTRD_OFS_A, 32'h80, 32'h0);
		wr(`UTRD_OFS_C, 32'h00);
		peer.send(mk(9'h0FB, 8, 0, 0, 10), 10);
		settle(4);
		rd(`UTRD_OFS_DATA, 32'hFFFFFFFF, 32'h1B);
		// synchronous slave transmit, bits change on rising external clock
		wr(`UTRD_OFS_C, 32'h46);
		wr(`UTRD_OFS_B, 32'h08);
		wr(`UTRD_OFS_DATA, 32'h5A);
		settle(2);
		check({31'h0, sout}, 32'h0);
		@(posedge pclk);
		for (int i = 0; i < 9; i++) begin
			xck <= 1'b1;
			repeat (8) @(posedge pclk);
			xck <= 1'b0;
			repeat (8) @(posedge pclk);
			check({31'h0, sout}, (i < 8) ? 32'((32'h5A >> i) & 32'h1) : 32'h1);
		end
		report_and_stop();
	end
endmodule // usart_tx_rx_datapath_tb
